// File: rtl/tks_pkg.sv
// constants, codes and crc helper shared by both ends of the touch-key link
// Notes on behaviour
// - one null command reads one response byte
// - setup load needs two copies within 100ms
// - ack when ready, ack again after burn
// - load aborts if byte gap exceeds 100ms
// - bad checksum gives zero instead of ack
// - host sends 100 bytes plus crc
// - zero checksum byte skips the check
// - block is burned even on bad checksum
// - sensing halts during load, then restarts
// - doubled cal-all starts cal, returns inverted code
// - doubled reset returns inverted code, then resets
// - status bit 6 unknown command, cleared by 0x0f
// - status bits 5, 3, 2 report faults
// - status bit 1 calibrating, bit 0 detect
// - status replies end with crc of all
// - first-key bit 7 means multiple touches
// - first-key bit 6 means cal or any fault except low ref
// - first-key bits 4:0 key number or 31
// - all-keys reply three detect bytes plus crc
// - error reply three error bytes plus crc
// - line fault reply one byte plus crc
// - sense line fault sets all bits
package tks_pkg;
	localparam logic [7:0] CMD_NULL   = 8'h00;
	localparam logic [7:0] CMD_SETUP  = 8'h01;
	localparam logic [7:0] CMD_CALALL = 8'h03;
	localparam logic [7:0] CMD_RESET  = 8'h04;
	localparam logic [7:0] CMD_GSTAT  = 8'h05;
	localparam logic [7:0] CMD_FIRST  = 8'h06;
	localparam logic [7:0] CMD_ALLKEY = 8'h07;
	localparam logic [7:0] CMD_ALLERR = 8'h0b;
	localparam logic [7:0] CMD_LINE   = 8'h0c;
	localparam logic [7:0] CMD_LAST   = 8'h0f;
	localparam logic [7:0] ACK_BYTE   = 8'hfe;
	localparam logic [7:0] NAK_BYTE   = 8'h00;
	localparam logic [7:0] CRC_POLY   = 8'h31;
	localparam logic [4:0] NO_KEY     = 5'h1f;
	localparam int         GS_COMM    = 6;
	localparam int         GS_FMEA    = 5;
	localparam int         GS_SYNC    = 3;
	localparam int         GS_CALF    = 2;
	localparam int         GS_CAL     = 1;
	localparam int         GS_DET     = 0;
	localparam int         FK_MULTI   = 7;
	localparam int         FK_FAULT   = 6;
	localparam int         NUM_KEYS   = 24;
	localparam logic [6:0] SETUP_LEN  = 7'h64;
	localparam int         GUARD_MS   = 100;
	localparam int         CLK_MHZ    = 100;
	localparam int         GUARD_CYC_DEF = GUARD_MS * 1000 * CLK_MHZ;
	localparam logic [3:0] SCLK_HALF  = 4'h8;
	localparam logic [4:0] PH_LAST    = 5'h10;
	localparam logic [4:0] PH_IDLE    = 5'h12;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [31:0] ADDR_TX   = 32'h0000_0000;
	localparam logic [31:0] ADDR_STAT = 32'h0000_0004;

	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
		end
		return r;
	endfunction
endpackage

// File: rtl/tks_if.sv
// spi link between host controller and touch-key device
`timescale 1ns/1ps
`default_nettype none
interface tks_if;
	logic sclk;
	logic ss_n;
	logic mosi;
	logic miso;
	modport dev (input sclk, input ss_n, input mosi, output miso);
	modport host (output sclk, output ss_n, output mosi, input miso);
endinterface
`default_nettype wire

// File: rtl/tks_dev.sv
// touch-key device end: spi slave command interpreter with reply queue
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module tks_dev
	import tks_pkg::*;
#(
	parameter int unsigned GUARD_CYC = GUARD_CYC_DEF
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	tks_if.dev               link,
	input  wire logic [23:0] key_detect,
	input  wire logic [23:0] key_error,
	input  wire logic        any_cal,
	input  wire logic        cal_fail5,
	input  wire logic        low_ref_err,
	input  wire logic        line_fault_fail,
	input  wire logic        sync_fail,
	input  wire logic [7:0]  drive_line_fault,
	input  wire logic        sense_line_fault,
	output logic             sensing_halt,
	output logic             cal_all_start,
	output logic             dev_reset,
	output logic             nv_we,
	output logic [6:0]       nv_addr,
	output logic [7:0]       nv_data,
	output logic             setup_done
);
	typedef enum logic {TM_RUN, TM_LOAD} tks_mode_t;

	logic [2:0] sclk_m_q, ss_m_q, mosi_m_q;
	logic       sclk_p_q;
	logic [7:0] rx_q, rx_d, tx_q, tx_d;
	logic [2:0] bit_q, bit_d;
	logic [7:0] resp_q [4];
	logic [7:0] resp_d [4];
	logic [2:0] rcnt_q, rcnt_d;
	logic [1:0] rptr_q, rptr_d;
	tks_mode_t  mode_q, mode_d;
	logic [7:0] pend_q, pend_d, last_q, last_d, crc_q, crc_d;
	logic       pend_v_q, pend_v_d, comm_q, comm_d, rst_arm_q, rst_arm_d;
	logic [23:0] tmr_q, tmr_d;
	logic [6:0] idx_q, idx_d;
	logic       cal_q, cal_d, rsto_q, rsto_d, we_q, we_d, done_q, done_d;
	logic [6:0] addr_q, addr_d;
	logic [7:0] wdat_q, wdat_d;

	// first stage feeds only the second; edges come from stages two and three
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sclk_m_q <= 3'h0;
			ss_m_q   <= 3'h7;
			mosi_m_q <= 3'h0;
			sclk_p_q <= 1'b0;
		end else begin
			sclk_m_q <= {sclk_m_q[1:0], link.sclk};
			ss_m_q   <= {ss_m_q[1:0], link.ss_n};
			mosi_m_q <= {mosi_m_q[1:0], link.mosi};
			sclk_p_q <= sclk_m_q[1];
		end
	end

	function automatic logic [4:0] first_key(input logic [23:0] k);
		logic [4:0] n;
		n = NO_KEY;
		for (int i = NUM_KEYS - 1; i >= 0; i--) begin
			if (k[i]) n = 5'(i);
		end
		return n;
	endfunction

	logic sel, rise, fall, ss_fall, byte_ok, multi;
	logic [7:0] cmd, gs, fk, lf;
	assign sel     = ~ss_m_q[1];
	assign rise    = sel & sclk_m_q[1] & ~sclk_p_q;
	assign fall    = sel & ~sclk_m_q[1] & sclk_p_q;
	assign ss_fall = ~ss_m_q[1] & ss_m_q[2];
	assign byte_ok = rise & (bit_q == 3'h7);
	assign cmd     = {rx_q[6:0], mosi_m_q[1]};
	assign multi   = (key_detect & (key_detect - 24'h1)) != 24'h0;
	always_comb begin
		gs = 8'h00;
		gs[GS_COMM] = comm_q;
		gs[GS_FMEA] = line_fault_fail;
		gs[GS_SYNC] = sync_fail;
		gs[GS_CALF] = cal_fail5 | low_ref_err;
		gs[GS_CAL]  = any_cal;
		gs[GS_DET]  = |key_detect;
	end
	// bit 5 unused, reads zero
	assign fk = {multi, any_cal | cal_fail5 | sync_fail | comm_q | line_fault_fail,
		1'b0, first_key(key_detect)};
	assign lf = sense_line_fault ? 8'hff : drive_line_fault;
	assign link.miso = tx_q[7];

	always_comb begin
		logic [7:0] c1;
		logic       pop;
		c1 = crc8(8'h00, cmd);
		pop = 1'b0;
		rx_d = rx_q;
		bit_d = bit_q;
		tx_d = tx_q;
		resp_d = resp_q;
		rcnt_d = rcnt_q;
		rptr_d = rptr_q;
		mode_d = mode_q;
		pend_d = pend_q;
		pend_v_d = pend_v_q;
		last_d = last_q;
		crc_d = crc_q;
		comm_d = comm_q;
		rst_arm_d = rst_arm_q;
		tmr_d = (tmr_q != 24'h0) ? tmr_q - 24'h1 : tmr_q;
		idx_d = idx_q;
		cal_d = 1'b0;
		rsto_d = 1'b0;
		we_d = 1'b0;
		done_d = 1'b0;
		addr_d = addr_q;
		wdat_d = wdat_q;
		if (!sel) bit_d = 3'h0;
		if (ss_fall) tx_d = (rcnt_q != 3'h0) ? resp_q[rptr_q] : 8'h00;
		if (fall) tx_d = {tx_q[6:0], 1'b0};
		if (rise) begin
			rx_d = cmd;
			bit_d = bit_q + 3'h1;
		end
		if (pend_v_q && tmr_q == 24'h0) pend_v_d = 1'b0; // pair window lapsed, silent
		if (mode_q == TM_LOAD && tmr_q == 24'h0) begin
			mode_d = TM_RUN; // byte gap too long
			rcnt_d = 3'h0;
		end
		if (byte_ok) begin
			// any byte in load mode, a null in run mode, drains one reply byte
			if (rcnt_q != 3'h0 && (mode_q == TM_LOAD || cmd == CMD_NULL)) begin
				pop = 1'b1;
				rptr_d = rptr_q + 2'h1;
				rcnt_d = rcnt_q - 3'h1;
				if (rst_arm_q && rcnt_q == 3'h1) begin
					rsto_d = 1'b1; // reset only after its ack left
					rst_arm_d = 1'b0;
				end
			end
			if (mode_q == TM_LOAD) begin
				tmr_d = 24'(GUARD_CYC);
				if (idx_q < SETUP_LEN) begin
					we_d = 1'b1; // burned regardless of checksum
					addr_d = idx_q;
					wdat_d = cmd;
					crc_d = crc8(crc_q, cmd);
					idx_d = idx_q + 7'h1;
				end else begin
					mode_d = TM_RUN;
					done_d = 1'b1;
					tmr_d = 24'h0;
					resp_d[0] = (cmd == 8'h00 || cmd == crc_q) ? ACK_BYTE : NAK_BYTE;
					rcnt_d = 3'h1;
					rptr_d = 2'h0;
				end
			end else if (cmd != CMD_NULL) begin
				last_d = cmd;
				pend_v_d = 1'b0; // any other byte breaks a pair
				rptr_d = 2'h0;
				rcnt_d = 3'h0;
				unique case (cmd)
					CMD_SETUP, CMD_CALALL, CMD_RESET: begin
						if (pend_v_q && pend_q == cmd && tmr_q != 24'h0) begin
							tmr_d = 24'h0;
							rcnt_d = 3'h1;
							if (cmd == CMD_SETUP) begin
								mode_d = TM_LOAD; // halt sensing
								idx_d = 7'h0;
								crc_d = 8'h00;
								tmr_d = 24'(GUARD_CYC);
								resp_d[0] = ACK_BYTE; // ready for data
							end else if (cmd == CMD_CALALL) begin
								cal_d = 1'b1;
								resp_d[0] = ~cmd;
							end else begin
								rst_arm_d = 1'b1;
								resp_d[0] = ~cmd;
							end
						end else begin
							pend_d = cmd;
							pend_v_d = 1'b1;
							tmr_d = 24'(GUARD_CYC);
						end
					end
					CMD_GSTAT, CMD_FIRST, CMD_LINE: begin
						resp_d[0] = (cmd == CMD_GSTAT) ? gs : (cmd == CMD_FIRST) ? fk : lf;
						resp_d[1] = crc8(c1, resp_d[0]);
						rcnt_d = 3'h2;
					end
					CMD_ALLKEY, CMD_ALLERR: begin
						for (int i = 0; i < 3; i++) begin
							resp_d[i] = (cmd == CMD_ALLKEY) ? key_detect[8*i +: 8] : key_error[8*i +: 8];
							c1 = crc8(c1, resp_d[i]);
						end
						resp_d[3] = c1;
						rcnt_d = 3'h4;
					end
					CMD_LAST: begin
						resp_d[0] = ~last_q;
						rcnt_d = 3'h1;
						comm_d = 1'b0;
					end
					default: comm_d = 1'b1;
				endcase
			end else begin
				pend_v_d = 1'b0; // a null between the copies breaks a pair too
			end
		end
		if (pop && rcnt_d == 3'h0) rptr_d = 2'h0;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_q <= 8'h00;
			bit_q <= 3'h0;
			tx_q <= 8'h00;
			for (int i = 0; i < 4; i++) resp_q[i] <= 8'h00;
			rcnt_q <= 3'h0;
			rptr_q <= 2'h0;
			mode_q <= TM_RUN;
			pend_q <= 8'h00;
			pend_v_q <= 1'b0;
			last_q <= 8'h00;
			crc_q <= 8'h00;
			comm_q <= 1'b0;
			rst_arm_q <= 1'b0;
			tmr_q <= 24'h0;
			idx_q <= 7'h0;
			cal_q <= 1'b0;
			rsto_q <= 1'b0;
			we_q <= 1'b0;
			done_q <= 1'b0;
			addr_q <= 7'h0;
			wdat_q <= 8'h00;
		end else begin
			rx_q <= rx_d;
			bit_q <= bit_d;
			tx_q <= tx_d;
			resp_q <= resp_d;
			rcnt_q <= rcnt_d;
			rptr_q <= rptr_d;
			mode_q <= mode_d;
			pend_q <= pend_d;
			pend_v_q <= pend_v_d;
			last_q <= last_d;
			crc_q <= crc_d;
			comm_q <= comm_d;
			rst_arm_q <= rst_arm_d;
			tmr_q <= tmr_d;
			idx_q <= idx_d;
			cal_q <= cal_d;
			rsto_q <= rsto_d;
			we_q <= we_d;
			done_q <= done_d;
			addr_q <= addr_d;
			wdat_q <= wdat_d;
		end
	end

	assign sensing_halt  = (mode_q == TM_LOAD);
	assign cal_all_start = cal_q;
	assign dev_reset     = rsto_q;
	assign nv_we         = we_q;
	assign nv_addr       = addr_q;
	assign nv_data       = wdat_q;
	assign setup_done    = done_q;
endmodule
`default_nettype wire

// File: rtl/tks_host.sv
// host end: axi4-lite controlled spi master sending one byte per order
`timescale 1ns/1ps
`default_nettype none
module tks_host
	import tks_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	tks_if.host              link,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	logic       aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d, bad_q, bad_d, rbad_q, rbad_d;
	logic [31:0] awa_q, awa_d, wd_q, wd_d, rd_q, rd_d;
	logic       wstb_q, wstb_d;
	logic       busy_q, busy_d, sclk_q, sclk_d, ss_q, ss_d, mosi_q, mosi_d;
	logic [7:0] txs_q, txs_d, rxs_q, rxs_d, rxb_q, rxb_d;
	logic [3:0] div_q, div_d;
	logic [4:0] ph_q, ph_d;
	logic [1:0] miso_s_q;

	// miso comes from another clock's logic through the pin
	always_ff @(posedge ref_clk) begin
		if (rst) miso_s_q <= 2'h0;
		else miso_s_q <= {miso_s_q[0], link.miso};
	end

	always_comb begin
		aw_d = aw_q;
		w_d = w_q;
		b_d = b_q;
		r_d = r_q;
		bad_d = bad_q;
		rbad_d = rbad_q;
		awa_d = awa_q;
		wd_d = wd_q;
		rd_d = rd_q;
		wstb_d = wstb_q;
		busy_d = busy_q;
		sclk_d = sclk_q;
		ss_d = ss_q;
		mosi_d = mosi_q;
		txs_d = txs_q;
		rxs_d = rxs_q;
		rxb_d = rxb_q;
		div_d = div_q;
		ph_d = ph_q;
		if (s_axi_awvalid && !aw_q && !b_q) begin
			aw_d = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_q && !b_q) begin
			w_d = 1'b1;
			wd_d = s_axi_wdata;
			wstb_d = s_axi_wstrb[0];
		end
		if (aw_q && w_q) begin
			aw_d = 1'b0;
			w_d = 1'b0;
			b_d = 1'b1;
			bad_d = awa_q[31:2] != ADDR_TX[31:2];
			// a byte order while busy is dropped, software polls busy first
			if (awa_q[31:2] == ADDR_TX[31:2] && wstb_q && !busy_q) begin
				busy_d = 1'b1; // a null byte here reads one reply
				ss_d = 1'b0;
				txs_d = wd_q[7:0];
				mosi_d = wd_q[7];
				div_d = 4'h0;
				ph_d = 5'h0;
			end
		end
		if (b_q && s_axi_bready) b_d = 1'b0;
		if (s_axi_arvalid && !r_q) begin
			r_d = 1'b1;
			rbad_d = s_axi_araddr[31:2] != ADDR_STAT[31:2];
			rd_d = rbad_d ? 32'h0 : {23'h0, busy_q, rxb_q};
		end
		if (r_q && s_axi_rready) r_d = 1'b0;
		// link clock made by dividing ref_clk, mode 0 framing
		if (busy_q) begin
			div_d = div_q + 4'h1;
			if (div_q == SCLK_HALF - 4'h1) begin
				div_d = 4'h0;
				ph_d = ph_q + 5'h1;
				if (ph_q < PH_LAST) begin
					sclk_d = ~sclk_q;
					if (!sclk_q) rxs_d = {rxs_q[6:0], miso_s_q[1]};
					else begin
						txs_d = {txs_q[6:0], 1'b0};
						mosi_d = txs_q[6];
					end
				end else if (ph_q == PH_LAST) begin
					ss_d = 1'b1;
					rxb_d = rxs_q;
				end else if (ph_q == PH_IDLE) begin
					busy_d = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			b_q <= 1'b0;
			r_q <= 1'b0;
			bad_q <= 1'b0;
			rbad_q <= 1'b0;
			awa_q <= 32'h0;
			wd_q <= 32'h0;
			rd_q <= 32'h0;
			wstb_q <= 1'b0;
			busy_q <= 1'b0;
			sclk_q <= 1'b0;
			ss_q <= 1'b1;
			mosi_q <= 1'b0;
			txs_q <= 8'h00;
			rxs_q <= 8'h00;
			rxb_q <= RESET_BYTE;
			div_q <= 4'h0;
			ph_q <= 5'h0;
		end else begin
			aw_q <= aw_d;
			w_q <= w_d;
			b_q <= b_d;
			r_q <= r_d;
			bad_q <= bad_d;
			rbad_q <= rbad_d;
			awa_q <= awa_d;
			wd_q <= wd_d;
			rd_q <= rd_d;
			wstb_q <= wstb_d;
			busy_q <= busy_d;
			sclk_q <= sclk_d;
			ss_q <= ss_d;
			mosi_q <= mosi_d;
			txs_q <= txs_d;
			rxs_q <= rxs_d;
			rxb_q <= rxb_d;
			div_q <= div_d;
			ph_q <= ph_d;
		end
	end

	assign s_axi_awready = !aw_q && !b_q;
	assign s_axi_wready  = !w_q && !b_q;
	assign s_axi_bvalid  = b_q;
	assign s_axi_bresp   = bad_q ? 2'h2 : 2'h0;
	assign s_axi_arready = !r_q;
	assign s_axi_rvalid  = r_q;
	assign s_axi_rdata   = rd_q;
	assign s_axi_rresp   = rbad_q ? 2'h2 : 2'h0;
	assign link.sclk = sclk_q;
	assign link.ss_n = ss_q;
	assign link.mosi = mosi_q;
endmodule
`default_nettype wire

// File: bench/tks_chk.sv
// wire-level checks on the touch-key spi link
`timescale 1ns/1ps
`default_nettype none
module tks_chk (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic ss_n,
	input wire logic mosi,
	input wire logic miso
);
	logic       sclk_q;
	logic [3:0] rise_q;
	logic [3:0] rise_d;

	// rising edges counted per frame, cleared while deselected
	always_comb begin
		rise_d = rise_q;
		if (ss_n) begin
			rise_d = 4'h0;
		end else if (sclk && !sclk_q) begin
			rise_d = rise_q + 4'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rise_q <= 4'h0;
			sclk_q <= 1'b0;
		end else begin
			rise_q <= rise_d;
			sclk_q <= sclk;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	chk_sclk_idle: assert property (ss_n |-> !sclk) else $error("sclk high outside frame");
	chk_frame_lead: assert property ($fell(ss_n) |-> (!sclk)[*8] ##1 sclk) else $error("bad frame lead");
	chk_sclk_high: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk) else $error("bad sclk high time");
	chk_sclk_low: assert property ($fell(sclk) |-> (!sclk)[*8]) else $error("bad sclk low time");
	chk_mosi_hold: assert property (sclk && $past(sclk) |-> $stable(mosi)) else $error("mosi moved");
	chk_miso_hold: assert property (sclk && $past(sclk) |-> $stable(miso)) else $error("miso moved");
	chk_eight_bits: assert property ($rose(ss_n) |-> rise_q == 4'h8) else $error("frame not 8 bits");
	chk_frame_gap: assert property ($rose(ss_n) |-> ss_n[*8]) else $error("frames too close");

	cover property ($rose(ss_n));
	cover property ($fell(sclk) && miso);
	cover property ($rose(sclk) && mosi);
endmodule
`default_nettype wire

// File: bench/testbench.sv
// self-checking bench: axi-driven host end talking to the device end
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
	import tks_pkg::*;
	// short window keeps the guard waits cheap
	localparam int unsigned GC = 2000;
	logic        ref_clk, rst;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [23:0] kd, ke;
	logic        cal, cf5, lre, lff, syn, slf, halt, cal_go, dreset, nv_we, sdone, comm;
	logic [7:0]  dlf, nv_data;
	logic [6:0]  nv_addr;
	logic [31:0] seed = 32'h05f4bc23;
	logic [7:0]  blk [100];
	int          error_cnt, num_checks, nv_cnt, cal_cnt, rst_cnt, done_cnt;

	tks_if link_if ();
	tks_host tks_host_inst (.ref_clk(ref_clk), .rst(rst), .link(link_if),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	tks_dev #(.GUARD_CYC(GC)) tks_dev_inst (.ref_clk(ref_clk), .rst(rst), .link(link_if),
		.key_detect(kd), .key_error(ke), .any_cal(cal), .cal_fail5(cf5), .low_ref_err(lre),
		.line_fault_fail(lff), .sync_fail(syn), .drive_line_fault(dlf), .sense_line_fault(slf),
		.sensing_halt(halt), .cal_all_start(cal_go), .dev_reset(dreset), .nv_we(nv_we),
		.nv_addr(nv_addr), .nv_data(nv_data), .setup_done(sdone));
	tks_chk tks_chk_inst (.ref_clk(ref_clk), .rst(rst), .sclk(link_if.sclk), .ss_n(link_if.ss_n),
		.mosi(link_if.mosi), .miso(link_if.miso));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [7:0] upd(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	function automatic logic [7:0] gstat();
		return {1'b0, comm, lff, 1'b0, syn, cf5 | lre, cal, |kd};
	endfunction

	// lowest touched index taken as first key
	function automatic logic [7:0] first();
		logic [4:0] k;
		k = NO_KEY;
		for (int i = NUM_KEYS - 1; i >= 0; i--) begin
			if (kd[i]) k = 5'(i);
		end
		return {$countones(kd) > 1, cal | cf5 | syn | comm | lff, 1'b0, k};
	endfunction

	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// bready and rready stay high, so a new call never re-drives them in the same step
	task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				r = bresp;
				break;
			end
		end
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				break;
			end
		end
	endtask

	task automatic xfer(input logic [7:0] b, output logic [7:0] rx);
		logic [31:0] d;
		logic [1:0]  r;
		wr(ADDR_TX, {24'h0, b}, r);
		do rd(ADDR_STAT, d, r); while (d[8] !== 1'b0);
		rx = d[7:0];
	endtask

	task automatic run_cmd(input logic [7:0] cmd, input logic [23:0] v, input int n);
		logic [7:0] rx, c;
		xfer(cmd, rx);
		c = upd(8'h00, cmd);
		for (int i = 0; i < n; i++) begin
			xfer(CMD_NULL, rx);
			`CHK(rx, v[8 * i +: 8])
			c = upd(c, v[8 * i +: 8]);
		end
		xfer(CMD_NULL, rx);
		`CHK(rx, c)
	endtask

	// mode 0 good crc, 1 bad crc, 2 zero crc, 3 stall mid-block
	task automatic load(input int m);
		logic [7:0] rx, c;
		nv_cnt = 0;
		c = 8'h00;
		xfer(CMD_SETUP, rx);
		xfer(CMD_SETUP, rx);
		for (int i = 0; i < 100; i++) begin
			blk[i] = 8'(rnd());
			c = upd(c, blk[i]);
			xfer(blk[i], rx);
			if (i == 0) `CHK(rx, ACK_BYTE)
			`CHK(halt, 1'b1)
			if (m == 3 && i == 49) begin
				repeat (GC + 100) @(posedge ref_clk);
				`CHK(halt, 1'b0)
				return;
			end
		end
		if (m == 1) c = (c == 8'h01) ? 8'h03 : c ^ 8'h01;
		if (m == 2) c = 8'h00;
		xfer(c, rx);
		xfer(CMD_NULL, rx);
		`CHK(rx, m == 1 ? NAK_BYTE : ACK_BYTE)
		`CHK(nv_cnt, 100)
		`CHK(done_cnt, m + 1)
		`CHK(halt, 1'b0)
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		if (nv_we === 1'b1) begin
			`CHK(nv_data, blk[nv_addr])
			nv_cnt++;
		end
		if (cal_go === 1'b1) cal_cnt++;
		if (dreset === 1'b1) rst_cnt++;
		if (sdone === 1'b1) done_cnt++;
	end

	initial begin
		repeat (95000) @(posedge ref_clk);
		error_cnt++;
		complete_run();
	end

	initial begin
		logic [7:0]  rx;
		logic [31:0] d;
		logic [1:0]  r;
		rst = 1'b1;
		{awaddr, wdata, araddr, awvalid, wvalid, arvalid} = '0;
		{bready, rready, wstrb} = 6'h3f;
		{kd, ke, dlf, cal, cf5, lre, lff, syn, slf, comm} = '0;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		wr(32'h0000_0010, 32'h0, r);
		`CHK(r, 2'h2)
		rd(32'h0000_0010, d, r);
		`CHK({r, d}, {2'h2, 32'h0})
		for (int it = 0; it < 4; it++) begin
			kd <= (it == 0) ? 24'h0 : (it == 1) ? 24'h000800 : 24'(rnd());
			ke <= 24'(rnd());
			{cal, cf5, lre, lff, syn, slf} <= 6'(rnd());
			dlf <= 8'(rnd());
			@(posedge ref_clk);
			run_cmd(CMD_GSTAT, {16'h0, gstat()}, 1);
			run_cmd(CMD_FIRST, {16'h0, first()}, 1);
			run_cmd(CMD_ALLKEY, kd, 3);
			run_cmd(CMD_ALLERR, ke, 3);
			run_cmd(CMD_LINE, {16'h0, slf ? 8'hff : dlf}, 1);
		end
		xfer(8'h02, rx);
		comm = 1'b1;
		run_cmd(CMD_GSTAT, {16'h0, gstat()}, 1);
		xfer(8'h02, rx);
		xfer(CMD_LAST, rx);
		xfer(CMD_NULL, rx);
		`CHK(rx, 8'hfd)
		comm = 1'b0;
		run_cmd(CMD_GSTAT, {16'h0, gstat()}, 1);
		xfer(CMD_CALALL, rx);
		xfer(CMD_NULL, rx);
		xfer(CMD_CALALL, rx);
		xfer(CMD_NULL, rx);
		`CHK(cal_cnt, 0)
		xfer(CMD_CALALL, rx);
		repeat (GC + 100) @(posedge ref_clk);
		xfer(CMD_CALALL, rx);
		`CHK(cal_cnt, 0)
		xfer(CMD_NULL, rx);
		xfer(CMD_CALALL, rx);
		xfer(CMD_CALALL, rx);
		xfer(CMD_NULL, rx);
		`CHK(rx, 8'hfc)
		`CHK(cal_cnt, 1)
		xfer(CMD_RESET, rx);
		xfer(CMD_RESET, rx);
		`CHK(rst_cnt, 0)
		xfer(CMD_NULL, rx);
		`CHK(rx, 8'hfb)
		`CHK(rst_cnt, 1)
		for (int m = 0; m < 4; m++) begin
			load(m);
		end
		complete_run();
	end
endmodule
`default_nettype wire
